// file: hw/lcd_seg_map.svh
`ifndef LCD_SEG_MAP_SVH
`define LCD_SEG_MAP_SVH

// =====================================================================
// register byte offsets on the apb window
`define SEG_CTRL_OFS 12'h000
`define SEG_STATUS_OFS 12'h004
`define SEG_LINES_OFS 12'h008

// =====================================================================
// control field positions and reset value
`define SEG_CTRL_HOLD_BIT 0
`define SEG_CTRL_FBLANK_BIT 1
`define SEG_CTRL_RESET 32'h0000_0000

// =====================================================================
// status field positions
`define SEG_STAT_LEVEL_LSB 0
`define SEG_STAT_OVF_BIT 8
`define SEG_STAT_BLANK_BIT 9
`define SEG_STAT_PAR_BIT 10

// =====================================================================
// geometry and timing
`define SEG_COUNT 80
`define SEG_FIFO_DEPTH 16
`define SEG_SYNC_WIDTH 10
`define SEG_CLK_PERIOD_PS 5000

`endif

// file: hw/lcd_seg_pkg.sv
package lcd_seg_pkg;
   // bias level driven per segment, two bits each on the output bus
   typedef enum logic [1:0] {
      select_bias_pos,
      unselect_bias_pos,
      unselect_bias_neg,
      select_bias_neg
   } bias_e;

   // fifo word: line latch marker, serial flag, data nibble
   typedef struct packed {
      logic load;
      logic serial;
      logic [3:0] nibble;
   } fifo_word_s;
endpackage

// file: hw/nibble_fifo.sv
`timescale 1ns/1ps
// =====================================================================
// flop based fifo with valid/ready on both sides
module nibble_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_q [DEPTH]; // storage entries
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] wr_q, wr_d; // write index
   logic [PW-1:0] rd_q, rd_d; // read index
   logic [CW-1:0] cnt_q, cnt_d; // occupancy
   logic push, pop;

   // honest flags straight from the occupancy count
   assign in_ready_o = (cnt_q != CW'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign level_o = cnt_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // =====================================================================
   // next state: indices wrap explicitly so any depth works
   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data_i;
         wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // registers only
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// file: hw/lcd_segment_data_driver.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "lcd_seg_map.svh"
// Notes on behaviour
// - polarity and pixel pick bias level
// - blank low forces select_bias_pos everywhere
// - pixel high selected, low unselected
// - pixel data arrives four bits wide
// - first nibble lands on top outputs
// - data sampled on shift clock falling edge
// - line latch fall copies shift latch out
// - chip disable high ignores shift clock
// - interface select picks parallel or serial
module lcd_segment_data_driver
   import lcd_seg_pkg::*;
#(
   parameter int SEGS = `SEG_COUNT,
   parameter int FIFO_DEPTH = `SEG_FIFO_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // pins from the lcd controller, all asynchronous
   input wire logic shift_clock_i,
   input wire logic line_latch_i,
   input wire logic chip_disable_in_i,
   input wire logic [3:0] pixel_nibble_in_i,
   input wire logic interface_select_i,
   input wire logic frame_polarity_i,
   input wire logic display_blank_n_i,
   // segment drive, two bits per output, see bias_e
   output logic [2*SEGS-1:0] segment_outputs_o,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);
   localparam int LW = $clog2(FIFO_DEPTH+1);

   // =====================================================================
   // input synchroniser: stage one feeds only stage two
   logic [`SEG_SYNC_WIDTH-1:0] pins;
   logic [`SEG_SYNC_WIDTH-1:0] sync1_q, sync1_d; // metastable stage
   logic [`SEG_SYNC_WIDTH-1:0] sync2_q, sync2_d; // settled copy
   logic clk_prev_q, clk_prev_d; // previous shift clock level
   logic lat_prev_q, lat_prev_d; // previous line latch level

   assign pins = {display_blank_n_i, frame_polarity_i, interface_select_i,
                  chip_disable_in_i, line_latch_i, shift_clock_i,
                  pixel_nibble_in_i};

   logic [3:0] nib_s;
   logic sck_s, lat_s, dis_s, par_s, pol_s, blank_n_s;
   assign nib_s = sync2_q[3:0];
   assign sck_s = sync2_q[4];
   assign lat_s = sync2_q[5];
   assign dis_s = sync2_q[6];
   assign par_s = sync2_q[7];
   assign pol_s = sync2_q[8];
   assign blank_n_s = sync2_q[9];

   // settled copies move one stage, edge history follows stage two
   always_comb begin
      sync1_d = pins;
      sync2_d = sync1_q;
      clk_prev_d = sck_s;
      lat_prev_d = lat_s;
   end

   // idle levels are high so no false edge is seen right after reset
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_q <= 10'h3f0;
         sync2_q <= 10'h3f0;
         clk_prev_q <= 1'b1;
         lat_prev_q <= 1'b1;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         clk_prev_q <= clk_prev_d;
         lat_prev_q <= lat_prev_d;
      end
   end

   // =====================================================================
   // capture side: falling edges become fifo words
   logic sck_fall, lat_fall;
   logic data_push; // a pixel word is offered this cycle
   logic load_pend_q, load_pend_d; // latch marker waiting for a slot
   logic ovf_q, ovf_d; // sticky: an edge found the fifo full
   fifo_word_s in_word, out_word;
   logic in_valid, in_ready, out_valid, out_ready;
   logic [LW-1:0] fifo_level;

   assign sck_fall = clk_prev_q && !sck_s;
   assign lat_fall = lat_prev_q && !lat_s;
   assign data_push = sck_fall && !dis_s;

   // pixel words take the slot first; a marker waits while the fifo is full, and one cycle at most
   // behind a pixel word because the controller keeps latch and clock edges well apart
   always_comb begin
      in_word = '0;
      in_valid = 1'b0;
      load_pend_d = load_pend_q || lat_fall;
      if (data_push) begin
         in_valid = 1'b1;
         in_word.serial = !par_s;
         in_word.nibble = nib_s;
      end else if (load_pend_q || lat_fall) begin
         in_valid = 1'b1;
         in_word.load = 1'b1;
         load_pend_d = !in_ready;
      end
   end

   // pins cannot be held off, so a refused pixel word is only flagged
   logic ovf_clr;
   always_comb begin
      ovf_d = ovf_q;
      if (ovf_clr) begin
         ovf_d = 1'b0;
      end
      if (in_valid && !in_ready) begin
         ovf_d = 1'b1; // set wins over a clear in the same cycle
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_pend_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         load_pend_q <= load_pend_d;
         ovf_q <= ovf_d;
      end
   end

   nibble_fifo #(
      .WIDTH($bits(fifo_word_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(in_valid),
      .in_ready_o(in_ready),
      .in_data_i(in_word),
      .out_valid_o(out_valid),
      .out_ready_i(out_ready),
      .out_data_o(out_word),
      .level_o(fifo_level)
   );

   // =====================================================================
   // drain side: shift latch and output latch
   logic [SEGS-1:0] shift_q, shift_d; // first latch
   logic [SEGS-1:0] line_q, line_d; // second latch, drives segments
   logic [15:0] lines_q, lines_d; // count of line transfers
   logic hold_q; // software stall of the drain
   logic pop;

   assign out_ready = !hold_q;
   assign pop = out_valid && out_ready;

   // parallel words enter at the bottom and push older ones up, so the
   // first word of a line ends on the top four segments
   always_comb begin
      shift_d = shift_q;
      line_d = line_q;
      lines_d = lines_q;
      if (pop) begin
         if (out_word.load) begin
            line_d = shift_q;
            lines_d = lines_q + 16'h0001;
         end else if (out_word.serial) begin
            shift_d = {shift_q[SEGS-2:0], out_word.nibble[3]};
         end else begin
            shift_d = {shift_q[SEGS-5:0], out_word.nibble};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shift_q <= '0;
         line_q <= '0;
         lines_q <= 16'h0000;
      end else begin
         shift_q <= shift_d;
         line_q <= line_d;
         lines_q <= lines_d;
      end
   end

   // =====================================================================
   // segment level selection, one copy per output
   logic fblank_q; // software forced blank
   logic [2*SEGS-1:0] seg_d, seg_q;

   genvar g;
   generate
      for (g = 0; g < SEGS; g++) begin : g_seg
         // local level keeps each slice of seg_d to a single driver
         bias_e lvl;
         always_comb begin
            if (!blank_n_s || fblank_q) begin
               lvl = select_bias_pos;
            end else if (!pol_s) begin
               lvl = line_q[g] ? select_bias_pos : unselect_bias_pos;
            end else begin
               lvl = line_q[g] ? select_bias_neg : unselect_bias_neg;
            end
         end
         assign seg_d[2*g+:2] = lvl;
      end
   endgenerate

   // blank at reset keeps the glass at a dc free level until reset is released
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seg_q <= {SEGS{select_bias_pos}};
      end else begin
         seg_q <= seg_d;
      end
   end
   assign segment_outputs_o = seg_q;

   // =====================================================================
   // apb slave: no wait state, pready rises in the first access cycle
   logic setup, wr_en;
   logic rdy_q, rdy_d;
   logic err_q, err_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic mapped;

   assign setup = psel_i && !penable_i;
   assign wr_en = psel_i && penable_i && rdy_q && pwrite_i && !err_q;
   assign mapped = (paddr_i == `SEG_CTRL_OFS) || (paddr_i == `SEG_STATUS_OFS)
                   || (paddr_i == `SEG_LINES_OFS);
   assign ovf_clr = wr_en && (paddr_i == `SEG_STATUS_OFS)
                    && pwdata_i[`SEG_STAT_OVF_BIT];
   assign hold_q = ctrl_q[`SEG_CTRL_HOLD_BIT];
   assign fblank_q = ctrl_q[`SEG_CTRL_FBLANK_BIT];

   // answer is prepared in the setup cycle, so read data is a flop
   always_comb begin
      rdy_d = setup;
      err_d = setup && !mapped;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      if (setup) begin
         rdata_d = 32'h0000_0000;
         if (paddr_i == `SEG_CTRL_OFS) begin
            rdata_d[1:0] = ctrl_q[1:0];
         end else if (paddr_i == `SEG_STATUS_OFS) begin
            rdata_d[`SEG_STAT_LEVEL_LSB+:LW] = fifo_level;
            rdata_d[`SEG_STAT_OVF_BIT] = ovf_q;
            rdata_d[`SEG_STAT_BLANK_BIT] = !blank_n_s || fblank_q;
            rdata_d[`SEG_STAT_PAR_BIT] = par_s;
         end else if (paddr_i == `SEG_LINES_OFS) begin
            rdata_d[15:0] = lines_q;
         end
      end
      if (wr_en && (paddr_i == `SEG_CTRL_OFS)) begin
         ctrl_d = {30'h0000_0000, pwdata_i[1:0]};
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= `SEG_CTRL_RESET;
      end else begin
         rdy_q <= rdy_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
      end
   end
   assign pready_o = rdy_q;
   assign pslverr_o = err_q;
   assign prdata_o = rdata_q;

   // =====================================================================
   // checks
   property p_blank_all;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !blank_n_s |=> (seg_q == {SEGS{select_bias_pos}});
   endproperty
   a_blank_all: assert property (p_blank_all)
      else $error("blank did not force select level");

   property p_pos_frame;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (blank_n_s && !fblank_q && !pol_s) |=>
         (seg_q[1:0] == ($past(line_q[0]) ? select_bias_pos : unselect_bias_pos));
   endproperty
   a_pos_frame: assert property (p_pos_frame)
      else $error("wrong level in positive frame");

   property p_neg_frame;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (blank_n_s && !fblank_q && pol_s && !line_q[SEGS-1]) |=>
         (seg_q[2*SEGS-1-:2] == unselect_bias_neg);
   endproperty
   a_neg_frame: assert property (p_neg_frame)
      else $error("off pixel not at unselected level");

   property p_par_shift;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (pop && !out_word.load && !out_word.serial) |=>
         (shift_q[3:0] == $past(out_word.nibble))
         && (shift_q[SEGS-1:4] == $past(shift_q[SEGS-5:0]));
   endproperty
   a_par_shift: assert property (p_par_shift)
      else $error("parallel word not shifted in by four");

   property p_ser_shift;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (pop && !out_word.load && out_word.serial) |=>
         (shift_q[0] == $past(out_word.nibble[3]));
   endproperty
   a_ser_shift: assert property (p_ser_shift)
      else $error("serial bit not taken from top data pin");

   property p_fall_push;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_prev_q && !sck_s && !dis_s) |->
         (in_valid && !in_word.load && (in_word.nibble == nib_s));
   endproperty
   a_fall_push: assert property (p_fall_push)
      else $error("falling edge did not offer pixel data");

   property p_dis_block;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      dis_s |-> !(in_valid && !in_word.load);
   endproperty
   a_dis_block: assert property (p_dis_block)
      else $error("data accepted while chip disabled");

   property p_latch_copy;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (pop && out_word.load) |=> (line_q == $past(shift_q)) ##1 $stable(line_q);
   endproperty
   a_latch_copy: assert property (p_latch_copy)
      else $error("line latch did not copy shift latch");

   property p_latch_reach;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (lat_fall && !hold_q && (fifo_level == '0) && !data_push) |=>
         ##[0:1] (pop && out_word.load);
   endproperty
   a_latch_reach: assert property (p_latch_reach)
      else $error("latch marker not drained in time");
endmodule

// file: dv/lcd_ctrl_model.sv
`timescale 1ns/1ps
// =====================================================================
// behavioural lcd controller driving the pixel link pins
module lcd_ctrl_model (
   input wire logic sys_clk_i,
   output logic shift_clock_o,
   output logic line_latch_o,
   output logic [3:0] pixel_nibble_o,
   output logic interface_select_o
);
   // half period of the shift clock in system cycles; 14 keeps both
   // setup and hold above 60 ns with margin for the two sync flops
   int half_cyc = 14;

   // every pin starts at a defined level, clocks idle high
   initial begin
      shift_clock_o = 1'b1;
      line_latch_o = 1'b1;
      pixel_nibble_o = 4'h0;
      interface_select_o = 1'b1;
   end

   // =====================================================================
   // pin sequences
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // strap change, done between lines only
   task automatic set_iface(input logic par);
      @(posedge sys_clk_i);
      interface_select_o <= par;
      wait_cyc(4);
   endtask

   // data stable around the fall; after hold the bus no longer shows it
   task automatic send_nibble(input logic [3:0] nib);
      @(posedge sys_clk_i);
      pixel_nibble_o <= nib;
      wait_cyc(half_cyc);
      shift_clock_o <= 1'b0;
      wait_cyc(half_cyc);
      shift_clock_o <= 1'b1;
      // serial mode keeps the three unused pins tied low
      if (interface_select_o) begin
         pixel_nibble_o <= ~nib;
      end else begin
         pixel_nibble_o <= {~nib[3], 3'h0};
      end
      wait_cyc(half_cyc);
   endtask

   // whole line, top segment first, then one latch pulse
   task automatic send_line(input logic [79:0] line);
      if (interface_select_o) begin
         for (int i = 0; i < 20; i++) begin
            send_nibble(line[79-4*i -: 4]);
         end
      end else begin
         for (int k = 0; k < 80; k++) begin
            send_nibble({line[79-k], 3'h0});
         end
      end
      line_latch_o <= 1'b0;
      wait_cyc(half_cyc);
      line_latch_o <= 1'b1;
      wait_cyc(half_cyc);
   endtask
endmodule

// file: dv/lcd_segment_data_driver_test.sv
`timescale 1ns/1ps
`include "lcd_seg_map.svh"
// =====================================================================
// bench: table of line cases, then hand-written awkward cases
module lcd_segment_data_driver_test;
   import lcd_seg_pkg::*;
   // row: line, polarity, blank pin, bias wanted for on and off bits
   typedef struct packed {
      logic [79:0] line;
      logic pol;
      logic bn;
      bias_e on_lvl;
      bias_e off_lvl;
   } row_s;
   localparam int NROWS = 5;
   localparam row_s ROWS [NROWS] = '{
      '{80'h0123456789abcdef1357, 1'b0, 1'b1, select_bias_pos, unselect_bias_pos},
      '{80'h0123456789abcdef1357, 1'b1, 1'b1, select_bias_neg, unselect_bias_neg},
      '{80'hffffffffffffffffffff, 1'b1, 1'b1, select_bias_neg, unselect_bias_neg},
      '{80'h00000000000000000000, 1'b0, 1'b1, select_bias_pos, unselect_bias_pos},
      '{80'ha5a5a5a5a5a5a5a5a5a5, 1'b1, 1'b0, select_bias_pos, select_bias_pos}
   };
   localparam logic [79:0] PAT = 80'ha5a5a5a5a5a5a5a5a5a5;

   // =====================================================================
   // signals
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic shift_clock, line_latch, iface_sel; // from the controller model
   logic [3:0] nibble;
   logic chip_dis = 1'b0;
   logic pol = 1'b0;
   logic blank_n = 1'b1;
   logic [159:0] segs;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   int err_count = 0;
   int n_tests = 0;
   int n_lines = 0; // latch pulses sent, mirrors the line counter

   always #2.5 sys_clk = ~sys_clk;

   lcd_ctrl_model i_ctl (
      .sys_clk_i(sys_clk), .shift_clock_o(shift_clock), .line_latch_o(line_latch),
      .pixel_nibble_o(nibble), .interface_select_o(iface_sel)
   );

   lcd_segment_data_driver i_dut (
      .sys_clk_i(sys_clk), .resetn_i(resetn), .shift_clock_i(shift_clock),
      .line_latch_i(line_latch), .chip_disable_in_i(chip_dis),
      .pixel_nibble_in_i(nibble), .interface_select_i(iface_sel),
      .frame_polarity_i(pol), .display_blank_n_i(blank_n),
      .segment_outputs_o(segs), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr)
   );

   // =====================================================================
   // compare tasks and expectations
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic cmp_segs(input logic [159:0] exp);
      n_tests++;
      if (segs !== exp) begin
         $display("unexpected at %0t: segments %h, wanted %h", $time, segs, exp);
         err_count++;
      end
   endtask

   // bit s of the line drives segment s
   function automatic logic [159:0] expect_segs(input logic [79:0] line,
                                                input bias_e on_l, input bias_e off_l);
      logic [159:0] r;
      for (int s = 0; s < 80; s++) begin
         r[2*s +: 2] = line[s] ? on_l : off_l;
      end
      return r;
   endfunction

   // =====================================================================
   // apb master: holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      input logic exp_err, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // a slave that never answers counts as a mismatch
      if (n >= 20) begin
         $display("unexpected at %0t: no pready from slave", $time);
         err_count++;
      end
      rd = prdata;
      cmp_word({31'h0, pslverr}, {31'h0, exp_err});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic e);
      logic [31:0] rd;
      apb(1'b0, addr, 32'h0000_0000, e, rd);
      cmp_word(rd, exp);
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, addr, d, 1'b0, rd);
   endtask

   // pins other than the link change just after an edge, then one line
   task automatic run_line(input logic [79:0] line, input logic p, input logic b);
      @(posedge sys_clk);
      pol <= p;
      blank_n <= b;
      i_ctl.send_line(line);
      n_lines++;
      repeat (12) @(posedge sys_clk);
   endtask

   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // =====================================================================
   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      cmp_segs('0);
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_chk(`SEG_CTRL_OFS, `SEG_CTRL_RESET, 1'b0);
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0400, 1'b0);
      rd_chk(`SEG_LINES_OFS, 32'h0000_0000, 1'b0);
      // unmapped word is refused and reads zero
      rd_chk(12'h00c, 32'h0000_0000, 1'b1);
      // table of ordinary line cases
      for (int i = 0; i < NROWS; i++) begin
         run_line(ROWS[i].line, ROWS[i].pol, ROWS[i].bn);
         cmp_segs(expect_segs(ROWS[i].line, ROWS[i].on_lvl, ROWS[i].off_lvl));
      end
      // blank released: the latched line reappears
      @(posedge sys_clk);
      blank_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cmp_segs(expect_segs(PAT, select_bias_neg, unselect_bias_neg));
      // chip disabled: shifting ignored, latch still copies the old line
      chip_dis <= 1'b1;
      run_line(80'h0, 1'b1, 1'b1);
      cmp_segs(expect_segs(PAT, select_bias_neg, unselect_bias_neg));
      chip_dis <= 1'b0;
      rd_chk(`SEG_LINES_OFS, 32'(n_lines), 1'b0);
      // blank forced from the control register
      wr(`SEG_CTRL_OFS, 32'h0000_0002);
      repeat (6) @(posedge sys_clk);
      cmp_segs('0);
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0600, 1'b0);
      wr(`SEG_CTRL_OFS, 32'h0000_0000);
      // drain stalled: fifo fills to 16, the rest overflows
      wr(`SEG_CTRL_OFS, 32'h0000_0001);
      for (int k = 0; k < 18; k++) begin
         i_ctl.send_nibble(4'h5);
      end
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0510, 1'b0);
      wr(`SEG_STATUS_OFS, 32'h0000_0100);
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0410, 1'b0);
      wr(`SEG_CTRL_OFS, 32'h0000_0000);
      // sixteen words drain one a cycle once the stall is lifted
      repeat (20) @(posedge sys_clk);
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0400, 1'b0);
      // serial mode: one bit a clock on the top data pin
      i_ctl.set_iface(1'b0);
      run_line(80'h0123456789abcdef1357, 1'b0, 1'b1);
      cmp_segs(expect_segs(80'h0123456789abcdef1357, select_bias_pos,
                           unselect_bias_pos));
      rd_chk(`SEG_STATUS_OFS, 32'h0000_0000, 1'b0);
      // mid-run reset: segments back to code zero, line counter cleared
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      cmp_segs('0);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_chk(`SEG_LINES_OFS, 32'h0000_0000, 1'b0);
      give_verdict();
   end

   // the sequence needs about 10k cycles (49 us); 200 us means a hang
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
endmodule
